// [dram_host.sv]
`timescale 1ns/1ps
// How it works
// - Refresh all 512 rows every 8 ms.
// - After power-up wait 200 us then issue eight row cycles.
// - Successive random cycles start at least 220 ns apart.
// - Row strobe stays high at least 90 ns between cycles.
// - Row strobe low at least 120 ns, at most 10 us.
// - Column strobe low 30 ns to 10 us.
// - Column strobe high at least 20 ns outside page access.
// - Column strobe falls 25 to 90 ns after row strobe.
// - Column address appears 20 to 60 ns after row strobe.
// - Column address valid 60 ns before row strobe rises.
// - Write select stays high until column or row strobe rises.
// - Write select low before column strobe makes an early write.
module dram_host (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // User request port.
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [dram_pkg::ADDR_W-1:0] req_addr,
  input wire logic [dram_pkg::DATA_W-1:0] req_wdata,
  output logic rd_valid,
  output logic [dram_pkg::DATA_W-1:0] rd_data,
  output logic init_done,
  // Memory pins, strobes active low.
  output logic row_strobe_n,
  output logic col_strobe_n,
  output logic write_sel_n,
  output logic [dram_pkg::HALF_W-1:0] multiplexed_addr,
  input wire logic [dram_pkg::DATA_W-1:0] dq_in,
  output logic [dram_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe
);
  import dram_pkg::*;

  typedef enum logic [2:0] {
    ST_POWERUP, ST_IDLE, ST_ROW, ST_COL, ST_PRE, ST_CBR_COL, ST_CBR_ROW
  } phase_t;

  typedef struct packed {
    phase_t phase;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [HALF_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic oe;
    logic is_write;
    logic [HALF_W-1:0] col;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic [3:0] wake;
    logic inited;
    logic refresh_due;
    logic [CNT_W-1:0] ref_cnt;
    logic [DATA_W-1:0] q1;
    logic [DATA_W-1:0] q2;
    logic [DATA_W-1:0] q3;
    logic arm;
  } host_state_t;

  host_state_t s_r;
  host_state_t s_nxt;
  dram_timer_if tif ();

  dram_timer u_timer (
    .clk(clk),
    .rst(rst),
    .tif(tif.timer)
  );

  // Wait lengths in timer units; the power-up pause is by far the longest.
  localparam logic [CNT_W-1:0] PWR_LOAD = CNT_W'(POWERUP_CYC);
  localparam logic [CNT_W-1:0] ROW_PRE_LOAD = CNT_W'(ROW_PRE_CYC);
  localparam logic [CNT_W-1:0] RCD_LOAD = CNT_W'(RCD_CYC);
  localparam logic [CNT_W-1:0] COL_LOAD = CNT_W'(COL_LOW_CYC);
  localparam logic [CNT_W-1:0] ROW_LOAD = CNT_W'(ROW_LOW_CYC);
  localparam logic [CNT_W-1:0] REF_LOAD = CNT_W'(REFRESH_GAP_CYC);

  // Sequencer for access, refresh and initialisation cycles.
  always_comb begin
    s_nxt = s_r;
    tif.load = 1'b0;
    tif.count = '0;
    s_nxt.rvalid = 1'b0;
    // Read data pins pass three flops; the value in stage three is taken as read data.
    s_nxt.q1 = dq_in;
    s_nxt.q2 = s_r.q1;
    s_nxt.q3 = s_r.q2;
    // Distributed refresh: one row per interval keeps all rows fresh.
    if (s_r.ref_cnt == '0) begin
      // Reload one short so that the period is exactly the refresh gap.
      s_nxt.ref_cnt = REF_LOAD - CNT_W'(1);
      s_nxt.refresh_due = 1'b1;
    end else begin
      s_nxt.ref_cnt = s_r.ref_cnt - CNT_W'(1);
    end
    // The power-up pause is loaded once, in the first cycle after reset.
    if (s_r.arm) begin
      s_nxt.arm = 1'b0;
      tif.load = 1'b1;
      tif.count = PWR_LOAD;
    end
    unique case (s_r.phase)
      ST_POWERUP: begin
        if (tif.done && !s_r.arm) begin
          s_nxt.phase = ST_PRE;
          tif.load = 1'b1;
          tif.count = ROW_PRE_LOAD;
        end
      end
      ST_IDLE: begin
        if (s_r.refresh_due || !s_r.inited) begin
          // Column strobe first; the memory supplies the row itself.
          // A new refresh demand raised in this same cycle wins over the clear.
          s_nxt.refresh_due = (s_r.ref_cnt == '0);
          s_nxt.cas_n = 1'b0;
          s_nxt.phase = ST_CBR_COL;
        end else if (req_valid) begin
          s_nxt.addr = req_addr[ADDR_W-1:HALF_W];
          s_nxt.col = req_addr[HALF_W-1:0];
          s_nxt.is_write = req_write;
          s_nxt.we_n = !req_write;
          s_nxt.dout = req_wdata;
          s_nxt.oe = req_write;
          s_nxt.phase = ST_ROW;
        end
      end
      ST_ROW: begin
        // Row strobe goes low one cycle after the row half settles.
        if (s_r.ras_n) begin
          s_nxt.ras_n = 1'b0;
          tif.load = 1'b1;
          tif.count = RCD_LOAD;
        end else if (tif.done) begin
          // Column address and strobe follow within the allowed window.
          s_nxt.addr = s_r.col;
          s_nxt.cas_n = 1'b0;
          s_nxt.phase = ST_COL;
          tif.load = 1'b1;
          tif.count = COL_LOAD;
        end
      end
      ST_COL: begin
        if (tif.done) begin
          // Sample only settled data; all strobes rise together.
          s_nxt.rdata = s_r.q3;
          s_nxt.rvalid = !s_r.is_write;
          s_nxt.ras_n = 1'b1;
          s_nxt.cas_n = 1'b1;
          s_nxt.phase = ST_PRE;
          tif.load = 1'b1;
          tif.count = ROW_PRE_LOAD;
        end
      end
      ST_PRE: begin
        // Write select and data released after the strobes rise.
        s_nxt.we_n = 1'b1;
        s_nxt.oe = 1'b0;
        if (tif.done) begin
          s_nxt.phase = ST_IDLE;
        end
      end
      ST_CBR_COL: begin
        s_nxt.ras_n = 1'b0;
        s_nxt.phase = ST_CBR_ROW;
        tif.load = 1'b1;
        tif.count = ROW_LOAD;
      end
      ST_CBR_ROW: begin
        if (tif.done) begin
          s_nxt.ras_n = 1'b1;
          s_nxt.cas_n = 1'b1;
          if (!s_r.inited) begin
            s_nxt.wake = s_r.wake + 4'h1;
            s_nxt.inited = (s_r.wake == 4'(WAKE_CYCLES - 1));
          end
          s_nxt.phase = ST_PRE;
          tif.load = 1'b1;
          tif.count = ROW_PRE_LOAD;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '{phase: ST_POWERUP, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, arm: 1'b1,
        default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state register; ready is combinational.
  assign req_ready = (s_r.phase == ST_IDLE) && s_r.inited && !s_r.refresh_due && !s_r.arm;
  assign rd_valid = s_r.rvalid;
  assign rd_data = s_r.rdata;
  assign init_done = s_r.inited;
  assign row_strobe_n = s_r.ras_n;
  assign col_strobe_n = s_r.cas_n;
  assign write_sel_n = s_r.we_n;
  assign multiplexed_addr = s_r.addr;
  assign dq_out = s_r.dout;
  assign dq_oe = s_r.oe;

  // Row strobe must stay low for the minimum pulse once it falls.
  logic [7:0] low_cnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt_r <= '0;
    end else if (!row_strobe_n) begin
      low_cnt_r <= low_cnt_r + 8'h01;
    end else begin
      low_cnt_r <= '0;
    end
  end

  chk_row_low_min: assert property (@(posedge clk) disable iff (rst)
    $rose(row_strobe_n) |-> $past(low_cnt_r) >= 8'(ROW_LOW_CYC - 1))
    else $error("row strobe low pulse too short");

  chk_row_high_min: assert property (@(posedge clk) disable iff (rst)
    $rose(row_strobe_n) |=> row_strobe_n [*2])
    else $error("row strobe precharge too short");

  chk_col_after_row: assert property (@(posedge clk) disable iff (rst)
    $fell(row_strobe_n) && col_strobe_n |=> $fell(col_strobe_n))
    else $error("column strobe not one cycle after row strobe");

  chk_write_hold: assert property (@(posedge clk) disable iff (rst)
    !col_strobe_n && write_sel_n |=> write_sel_n || col_strobe_n)
    else $error("write select dropped during read");

  chk_early_write: assert property (@(posedge clk) disable iff (rst)
    $fell(col_strobe_n) && !row_strobe_n && dq_oe |-> !write_sel_n)
    else $error("write data driven without early write");

  chk_col_low_min: assert property (@(posedge clk) disable iff (rst)
    $fell(col_strobe_n) |-> !col_strobe_n [*2])
    else $error("column strobe pulse too short");

  chk_refresh_order: assert property (@(posedge clk) disable iff (rst)
    $fell(row_strobe_n) && !$past(col_strobe_n) |-> s_r.phase == ST_CBR_ROW)
    else $error("refresh ordering broken");

  chk_no_access_early: assert property (@(posedge clk) disable iff (rst)
    !init_done |-> !dq_oe)
    else $error("access before initialisation");

endmodule

// [dram_model.sv]
`timescale 1ns/1ps
// Behavioural memory module: stores words, answers reads and counts pin timing faults.
module dram_model (
  // Reset, seen only to time the power-up pause.
  input wire logic rst,
  // Memory pins.
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_sel_n,
  input wire logic [9:0] multiplexed_addr,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe,
  output wire logic [7:0] dq,
  // Counts for the bench.
  output int n_bad,
  output int n_rows,
  output int n_refresh
);
  logic [7:0] store [int];
  logic [7:0] q_r;
  logic [7:0] last = 8'h00;
  logic q_oe = 1'b0;
  logic [9:0] row;
  realtime t_rst, t_rf, t_rr, t_cf, t_cr, t_a, t_ref;

  // A released line shows the inverse of its last value, never a kind guess.
  assign dq = q_oe ? q_r : dq_oe ? dq_out : ~last;
  always @(dq) if (q_oe || dq_oe) last = dq;

  task automatic lim(input string what, input realtime v, input realtime lo, input realtime hi);
    if (v < lo || v > hi) begin
      n_bad++;
      $display("MISMATCH %s expected %0.0f to %0.0f seen %0.0f", what, lo, hi, v);
    end
  endtask

  // Read data is garbage until the latest of the access limits has passed.
  task automatic read_out(input int a);
    realtime v;
    v = t_rf + 120;
    if (t_cf + 30 > v) v = t_cf + 30;
    if (t_a + 60 > v) v = t_a + 60;
    if (t_cr > t_rf && t_cr + 65 > v) v = t_cr + 65;
    #5 q_oe = 1'b1;
    q_r = ~store[a];
    #(v - $realtime) q_r = store[a];
  endtask

  always @(negedge rst) t_rst = $realtime;
  always @(multiplexed_addr) t_a = $realtime;

  // Row fall opens a row, or refreshes when the column strobe is already low.
  always @(negedge row_strobe_n) begin
    n_rows++;
    if (n_rows == 1) lim("power-up pause", $realtime - t_rst, 200000, 1e9);
    else begin
      lim("row precharge", $realtime - t_rr, 90, 1e9);
      lim("cycle time", $realtime - t_rf, 220, 1e9);
    end
    t_rf = $realtime;
    if (!col_strobe_n) begin
      n_refresh++;
      if (n_refresh == 8) t_ref = $realtime;
      if (n_refresh > 8) lim("refresh pace", $realtime - t_ref, 0, (n_refresh - 8) * 15625 + 1000);
    end else row = multiplexed_addr;
  end

  // Row rise closes the cycle.
  always @(posedge row_strobe_n) begin
    t_rr = $realtime;
    if (n_rows > 0) lim("row low", t_rr - t_rf, 120, 10000);
  end

  // Column fall with the row open reads or writes one word of that row.
  always @(negedge col_strobe_n) begin
    if (t_cr > 0) lim("column precharge", $realtime - t_cr, 20, 1e9);
    t_cf = $realtime;
    // Address and strobe change in one step; let the address settle before latching it.
    #1;
    if (!row_strobe_n) begin
      if (t_a < t_rf) t_a = t_rf + 20;
      lim("row to column", t_cf - t_rf, 25, 90);
      lim("column address", t_a - t_rf, 20, 60);
      lim("address lead", t_rf + 120 - t_a, 60, 1e9);
      if (write_sel_n) begin
        fork read_out({row, multiplexed_addr}); join_none
      end else if (dq_oe) store[{row, multiplexed_addr}] = dq_out;
      else lim("write data driven", 0, 1, 1);
    end
  end

  // Column rise ends the pulse and lets go of the data pins late.
  always @(posedge col_strobe_n) begin
    t_cr = $realtime;
    if (t_cf > 0) lim("column low", t_cr - t_cf, 30, 10000);
    #35 q_oe = 1'b0;
  end

  // Write select must not fall while a read still holds the pins.
  always @(negedge write_sel_n) begin
    if (!col_strobe_n && !row_strobe_n && q_oe) lim("read select hold", 0, 1, 1);
  end
endmodule

// [dram_module_1mx8_interface_bench.sv]
`timescale 1ns/1ps
// Self-checking bench for the memory host facing a behavioural memory module.
module dram_module_1mx8_interface_bench;
  import dram_pkg::*;
  logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic req_ready, rd_valid, init_done, row_strobe_n, col_strobe_n, write_sel_n, dq_oe;
  logic [DATA_W-1:0] rd_data, dq_out;
  logic [HALF_W-1:0] multiplexed_addr;
  wire [DATA_W-1:0] dq;
  int n_bad, n_rows, n_refresh, n_errors = 0, n_checks = 0, cyc = 0;
  logic [31:0] seed = 32'h0000381D;
  logic [DATA_W-1:0] ref_mem [int];
  logic [DATA_W-1:0] exp_q [$];
  int addr_q [$];
  logic [ADDR_W-1:0] edge_a [4] = '{20'h00000, 20'hFFFFF, 20'h003FF, 20'hFFC00};

  dram_host dut_u (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .rd_valid(rd_valid),
    .rd_data(rd_data), .init_done(init_done), .row_strobe_n(row_strobe_n),
    .col_strobe_n(col_strobe_n), .write_sel_n(write_sel_n),
    .multiplexed_addr(multiplexed_addr), .dq_in(dq), .dq_out(dq_out), .dq_oe(dq_oe));
  dram_model mem_u (.rst(rst), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
    .write_sel_n(write_sel_n), .multiplexed_addr(multiplexed_addr), .dq_out(dq_out),
    .dq_oe(dq_oe), .dq(dq), .n_bad(n_bad), .n_rows(n_rows), .n_refresh(n_refresh));

  // Free-running 20 MHz clock.
  initial forever #25 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cmp_data(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_count(input string what, input int exp, input int got);
    n_checks++;
    if (got != exp) begin
      n_errors++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One request held from a falling edge until the edge that takes it; reads note their answer.
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(negedge clk);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    #1;
    while (req_ready !== 1'b1 && n < 2000) begin
      @(negedge clk);
      #1;
      n++;
    end
    if (n == 2000) cmp_count("request taken", 1, 0);
    @(posedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    if (wr) begin
      ref_mem[a] = d;
      addr_q.push_back(a);
    end else exp_q.push_back(ref_mem[a]);
  endtask

  // Cycle ceiling cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  // Each read result is matched against the oldest noted value.
  always @(negedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) cmp_count("unexpected read", 0, 1);
      else cmp_data("read data", exp_q.pop_front(), rd_data);
    end
  end

  // Main sequence: wake-up, edge addresses, random traffic, idle refresh, read-back.
  initial begin
    int a;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    while (init_done !== 1'b1 && cyc < 6000) @(negedge clk);
    cmp_count("wake row cycles", 1, int'(n_rows >= 8));
    cmp_count("ready after pause", 1, int'(cyc >= 4012));
    $display("test wake done");
    foreach (edge_a[i]) access(1'b1, edge_a[i], 8'(rnd()));
    foreach (edge_a[i]) access(1'b0, edge_a[i], 8'h00);
    $display("test edge addresses done");
    repeat (40) begin
      if (rnd() % 2 || addr_q.size() == 0) access(1'b1, 20'(rnd()), 8'(rnd()));
      else access(1'b0, 20'(addr_q[rnd() % addr_q.size()]), 8'(rnd()));
    end
    $display("test random traffic done");
    a = n_refresh;
    repeat (2000) @(negedge clk);
    cmp_count("idle refreshes", 1, int'(n_refresh - a >= 6));
    foreach (ref_mem[k]) access(1'b0, 20'(k), 8'h00);
    while (exp_q.size() > 0 && cyc < 19000) @(negedge clk);
    repeat (10) @(negedge clk);
    foreach (ref_mem[k]) cmp_data("stored word", ref_mem[k], mem_u.store[k]);
    cmp_count("pin timing faults", 0, n_bad);
    $display("test read-back done");
    end_of_test();
  end
endmodule

// [dram_pkg.sv]
package dram_pkg;
  // Clock period in picoseconds (20 MHz).
  localparam int unsigned CLK_PS = 50000;
  // Timing figures in ns, slower grade, so both grades are met.
  localparam int unsigned CYCLE_TIME_NS = 220;
  localparam int unsigned ROW_PRECHARGE_NS = 90;
  localparam int unsigned ROW_LOW_MIN_NS = 120;
  localparam int unsigned COL_LOW_MIN_NS = 30;
  localparam int unsigned COLUMN_PRECHARGE_NS = 20;
  localparam int unsigned ROW_TO_COLUMN_MIN_NS = 25;
  localparam int unsigned ROW_ACCESS_NS = 120;
  localparam int unsigned COLUMN_ACCESS_NS = 30;
  localparam int unsigned COLADDR_LEAD_NS = 60;
  localparam int unsigned POWERUP_US = 200;
  localparam int unsigned REFRESH_MS = 8;
  localparam int unsigned REFRESH_ROWS = 512;
  localparam int unsigned WAKE_CYCLES = 8;
  // Derived cycle counts; least times round up.
  localparam int unsigned ROW_PRE_CYC = (ROW_PRECHARGE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned RCD_CYC = (ROW_TO_COLUMN_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  // Read data pass three input flops before they are taken.
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned COL_LOW_CYC =
    (ROW_ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS + SYNC_STAGES - RCD_CYC;
  localparam int unsigned ROW_LOW_CYC = (ROW_LOW_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned POWERUP_CYC = POWERUP_US * 1000000 / CLK_PS;
  // Longest time between refreshes rounds down; worked in ns so it fits 32 bits.
  localparam int unsigned REFRESH_GAP_CYC =
    REFRESH_MS * 1000000 / (CLK_PS / 1000) / REFRESH_ROWS;
  // Widths.
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned HALF_W = 10;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W = 16;
endpackage

// [dram_timer.sv]
`timescale 1ns/1ps
// Down counter that flags when a loaded wait has elapsed.
module dram_timer (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Control.
  dram_timer_if.timer tif
);
  import dram_pkg::*;
  typedef struct packed {
    logic [CNT_W-1:0] left;
  } timer_state_t;
  timer_state_t s_r;
  timer_state_t s_nxt;

  // Reload on request, otherwise count down to zero.
  always_comb begin
    s_nxt = s_r;
    if (tif.load) begin
      s_nxt.left = tif.count;
    end else if (s_r.left != '0) begin
      s_nxt.left = s_r.left - CNT_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Done in the last cycle of a wait, so the owner acts on that edge; no path back to load.
  assign tif.done = (s_r.left <= CNT_W'(1));
endmodule

// [dram_timer_if.sv]
`timescale 1ns/1ps
interface dram_timer_if;
  import dram_pkg::*;
  logic load;
  logic [CNT_W-1:0] count;
  logic done;
  modport owner (output load, output count, input done);
  modport timer (input load, input count, output done);
endinterface
